// ==== tb.sv ====
// Self-checking bench for the lane enable decoder.
// Assumes one wait cycle per bus access and three edges from pin to enable.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                          clk = 1'b0, rst = 1'b1, clk_en = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [3:0]                    addr = 4'h0;
  logic [31:0]                   wdata = 32'h0000_0000, rdata, rv;
  logic                          wait_o;
  logic [2:0]                    phy_a, phy_b, allow = 3'h7, ea, eb;
  typec_orient_pkg::pin_bundle_t cmd = typec_orient_pkg::PINS_RST, pins;
  int                            bad_count = 0, n_compared = 0;
  always #25 clk = ~clk;
  typec_ctrl_model u_model (.clk_in(clk), .cmd_in(cmd), .pins_out(pins));
  typec_phy_orientation_control dut (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(clk_en),
    .PORT_ATTACH_IN(pins.port_attach), .PORT_ORIENT_IN(pins.port_orient),
    .ORIENT_A_ATTACH_IN(pins.orient_a_attach), .ORIENT_B_ATTACH_IN(pins.orient_b_attach),
    .ATTACH_POLARITY_SEL_IN(pins.attach_polarity_sel),
    .CONTROL_MODE_SEL_IN(pins.control_mode_sel), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_o), .PHY_A_EN_OUT(phy_a),
    .PHY_B_EN_OUT(phy_b));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Request stays up until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= ~w; wr <= w; addr <= a; wdata <= d;
    do begin @(posedge clk); n++; end while (wait_o !== 1'b0 && n < 20);
    if (n >= 20) bad_count++;
    rv = rdata;
    rd <= 1'b0; wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task restart(input logic pol, input logic mode);
    rst <= 1'b1;
    cmd.attach_polarity_sel <= pol;
    cmd.control_mode_sel <= mode;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : restart
  task apply(input logic [2:0] at, input logic [2:0] ori, input logic [2:0] ma,
             input logic [2:0] mb);
    cmd.port_attach <= at; cmd.port_orient <= ori;
    cmd.orient_a_attach <= ma; cmd.orient_b_attach <= mb;
    repeat (6) @(posedge clk);
    ea = (cmd.control_mode_sel ? ma : (at & ~ori)) & allow;
    eb = (cmd.control_mode_sel ? mb : (at & ori)) & allow;
    check(32'(phy_a), 32'(ea));
    check(32'(phy_b), 32'(eb));
    bus(1'b0, typec_orient_pkg::LANE_STATE_OFS, 32'h0000_0000);
    check(rv, {22'h0, cmd.attach_polarity_sel, cmd.control_mode_sel, 1'b0, eb, 1'b0, ea});
  endtask : apply
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    restart(1'b0, 1'b0);
    check(32'(phy_a | phy_b), 32'h0000_0000);
    bus(1'b0, typec_orient_pkg::LANE_STATE_OFS, 32'h0000_0000);
    check(rv, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      for (int p = 0; p < 2; p++) begin
        restart(p[0], m[0]);
        apply(3'h5, 3'h4, 3'h3, 3'h6);
        apply(3'h2, 3'h2, 3'h4, 3'h0);
      end
    end
    bus(1'b1, typec_orient_pkg::LANE_CTRL_OFS, 32'h0000_0002);
    allow = 3'h2;
    bus(1'b0, typec_orient_pkg::LANE_CTRL_OFS, 32'h0000_0000);
    check(rv, 32'h0000_0002);
    bus(1'b0, 4'hc, 32'h0000_0000);
    check(rv, 32'h0000_0000);
    apply(3'h7, 3'h0, 3'h7, 3'h7);
    // Pins move while frozen, so the enables must hold the old value
    clk_en <= 1'b0;
    cmd.port_attach <= 3'h0; cmd.port_orient <= 3'h0;
    cmd.orient_a_attach <= 3'h0; cmd.orient_b_attach <= 3'h0;
    repeat (6) @(posedge clk);
    check(32'(phy_a), 32'(ea));
    check(32'(phy_b), 32'(eb));
    clk_en <= 1'b1;
    apply(3'h0, 3'h0, 3'h0, 3'h0);
    stop_test();
  end
endmodule : tb
`default_nettype wire

// ==== typec_ctrl_model.sv ====
// Model of the external Type-C controller that drives the lane pins.
// Assumes the bench gives logical levels (asserted = 1) on the core clock.
`timescale 1ns/10ps
`default_nettype none
module typec_ctrl_model (
  input  wire logic                          clk_in,
  input  wire typec_orient_pkg::pin_bundle_t cmd_in,
  output var  typec_orient_pkg::pin_bundle_t pins_out
);
  // Mode and polarity follow cmd_in, which the bench moves only in reset
  // Zero on both stands for a floating pin held by its pull-down
  always_ff @(posedge clk_in) begin
    pins_out <= cmd_in ^ {{12{cmd_in.attach_polarity_sel}}, 2'b00};
  end
endmodule : typec_ctrl_model
`default_nettype wire

// ==== typec_orient_checker.sv ====
// Concurrent checks on the lane enable decoder's ports.
// Assumes the pin to enable latency of three enabled edges.
`timescale 1ns/10ps
`default_nettype none
module typec_orient_checker #(
  parameter int NUM_PORTS = 3
) (
  input wire logic                 CORE_CLK_IN,
  input wire logic                 RST_IN,
  input wire logic                 CLK_EN_IN,
  input wire logic [NUM_PORTS-1:0] PORT_ATTACH_IN,
  input wire logic [NUM_PORTS-1:0] PORT_ORIENT_IN,
  input wire logic [NUM_PORTS-1:0] ORIENT_A_ATTACH_IN,
  input wire logic [NUM_PORTS-1:0] ORIENT_B_ATTACH_IN,
  input wire logic                 ATTACH_POLARITY_SEL_IN,
  input wire logic                 CONTROL_MODE_SEL_IN,
  input wire logic                 AVS_READ_IN,
  input wire logic                 AVS_WRITE_IN,
  input wire logic [31:0]          AVS_READDATA_OUT,
  input wire logic                 AVS_WAITREQUEST_OUT,
  input wire logic [NUM_PORTS-1:0] PHY_A_EN_OUT,
  input wire logic [NUM_PORTS-1:0] PHY_B_EN_OUT
);
  typec_orient_pkg::pin_bundle_t d1_r, d2_r, d3_r;
  logic [1:0]                    run_r;
  logic [NUM_PORTS-1:0]          inv, at, ori, exp_a, exp_b;
  // Allow mask is invisible here, so enables are checked as a subset
  always_ff @(posedge CORE_CLK_IN) begin
    d1_r  <= {PORT_ATTACH_IN, PORT_ORIENT_IN, ORIENT_A_ATTACH_IN, ORIENT_B_ATTACH_IN,
              ATTACH_POLARITY_SEL_IN, CONTROL_MODE_SEL_IN};
    d2_r  <= d1_r;
    d3_r  <= d2_r;
    run_r <= (RST_IN || !CLK_EN_IN) ? 2'h0 : ((run_r == 2'h3) ? 2'h3 : run_r + 2'h1);
  end
  assign inv   = {NUM_PORTS{d3_r.attach_polarity_sel}};
  assign at    = d3_r.port_attach ^ inv;
  assign ori   = d3_r.port_orient ^ inv;
  assign exp_a = d3_r.control_mode_sel ? (d3_r.orient_a_attach ^ inv) : (at & ~ori);
  assign exp_b = d3_r.control_mode_sel ? (d3_r.orient_b_attach ^ inv) : (at & ori);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  AST_A_DECODE: assert property (run_r == 2'h3 |-> (PHY_A_EN_OUT & ~exp_a) == '0)
    else $error("orientation A enable without cause");
  AST_B_DECODE: assert property (run_r == 2'h3 |-> (PHY_B_EN_OUT & ~exp_b) == '0)
    else $error("orientation B enable without cause");
  AST_M1_EXCL: assert property (run_r == 2'h3 && !d3_r.control_mode_sel
    |-> (PHY_A_EN_OUT & PHY_B_EN_OUT) == '0)
    else $error("both lanes enabled in mode 1");
  AST_RST_CLEAR: assert property ($fell(RST_IN) |-> PHY_A_EN_OUT == '0 && PHY_B_EN_OUT == '0)
    else $error("lane enables not cleared by reset");
  AST_FREEZE: assert property (!CLK_EN_IN |=> $stable(PHY_A_EN_OUT) && $stable(PHY_B_EN_OUT))
    else $error("lane enables moved while clock enable low");
  AST_WAIT_ONE: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT && CLK_EN_IN
    |=> !AVS_WAITREQUEST_OUT) else $error("bus wait longer than one cycle");
  AST_WAIT_IDLE: assert property (!(AVS_READ_IN || AVS_WRITE_IN) |-> !AVS_WAITREQUEST_OUT)
    else $error("waitrequest high with no request");
  AST_RDATA_HOLD: assert property (!AVS_READ_IN |=> $stable(AVS_READDATA_OUT))
    else $error("read data moved without a read");
  cover property (run_r == 2'h3 && d3_r.control_mode_sel && PHY_B_EN_OUT != '0);
  cover property (run_r == 2'h3 && d3_r.attach_polarity_sel && PHY_A_EN_OUT != '0);
  cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
endmodule : typec_orient_checker
bind typec_phy_orientation_control typec_orient_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .CLK_EN_IN(CLK_EN_IN),
  .PORT_ATTACH_IN(PORT_ATTACH_IN), .PORT_ORIENT_IN(PORT_ORIENT_IN),
  .ORIENT_A_ATTACH_IN(ORIENT_A_ATTACH_IN), .ORIENT_B_ATTACH_IN(ORIENT_B_ATTACH_IN),
  .ATTACH_POLARITY_SEL_IN(ATTACH_POLARITY_SEL_IN), .CONTROL_MODE_SEL_IN(CONTROL_MODE_SEL_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .PHY_A_EN_OUT(PHY_A_EN_OUT),
  .PHY_B_EN_OUT(PHY_B_EN_OUT));
`default_nettype wire

// ==== typec_orient_pkg.sv ====
// Constants and carrier types for the Type-C PHY lane enable decoder.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.

package typec_orient_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS   = 3;
  localparam int ADDR_W      = 4;
  localparam int DATA_W      = 32;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LANE_CTRL_OFS  = 4'h0;
  localparam logic [ADDR_W-1:0] LANE_STATE_OFS = 4'h4;

  // Lane control: bits [2:0] allow PHY enables per port
  localparam int                   CTRL_ALLOW_LSB = 0;
  localparam logic [NUM_PORTS-1:0] CTRL_ALLOW_RST = 3'h7;

  // Lane state: [2:0] orientation A enables, [6:4] orientation B enables,
  // [8] control mode, [9] attach polarity
  localparam int STATE_A_LSB    = 0;
  localparam int STATE_B_LSB    = 4;
  localparam int STATE_MODE_BIT = 8;
  localparam int STATE_POL_BIT  = 9;

  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    MODE_ATTACH_ORIENT = 1'b0,  // Control mode 1
    MODE_SPLIT_ATTACH  = 1'b1   // Control mode 2
  } control_mode_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0] port_attach;
    logic [NUM_PORTS-1:0] port_orient;
    logic [NUM_PORTS-1:0] orient_a_attach;
    logic [NUM_PORTS-1:0] orient_b_attach;
    logic                 attach_polarity_sel;
    logic                 control_mode_sel;
  } pin_bundle_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0] phy_a;
    logic [NUM_PORTS-1:0] phy_b;
  } phy_en_t;

  localparam pin_bundle_t PINS_RST   = '0;
  localparam phy_en_t     PHY_EN_RST = '0;

endpackage : typec_orient_pkg

// ==== typec_phy_orientation_control.sv ====
// Decodes Type-C attach and orientation pins into PHY lane enables.
// Assumes asynchronous pins from a Type-C controller and an Avalon-MM master
// on CORE_CLK_IN; mode and polarity pins are held static outside reset.

`timescale 1ns/10ps
`default_nettype none

module typec_phy_orientation_control #(
  parameter int NUM_PORTS = typec_orient_pkg::NUM_PORTS
) (
  input  wire logic                                   CORE_CLK_IN,
  input  wire logic                                   RST_IN,
  input  wire logic                                   CLK_EN_IN,
  input  wire logic [NUM_PORTS-1:0]                   PORT_ATTACH_IN,
  input  wire logic [NUM_PORTS-1:0]                   PORT_ORIENT_IN,
  input  wire logic [NUM_PORTS-1:0]                   ORIENT_A_ATTACH_IN,
  input  wire logic [NUM_PORTS-1:0]                   ORIENT_B_ATTACH_IN,
  input  wire logic                                   ATTACH_POLARITY_SEL_IN,
  input  wire logic                                   CONTROL_MODE_SEL_IN,
  input  wire logic [typec_orient_pkg::ADDR_W-1:0]    AVS_ADDRESS_IN,
  input  wire logic                                   AVS_READ_IN,
  input  wire logic                                   AVS_WRITE_IN,
  input  wire logic [typec_orient_pkg::DATA_W-1:0]    AVS_WRITEDATA_IN,
  input  wire logic [typec_orient_pkg::DATA_W/8-1:0]  AVS_BYTEENABLE_IN,
  output var  logic [typec_orient_pkg::DATA_W-1:0]    AVS_READDATA_OUT,
  output logic                                        AVS_WAITREQUEST_OUT,
  output logic [NUM_PORTS-1:0]                        PHY_A_EN_OUT,
  output logic [NUM_PORTS-1:0]                        PHY_B_EN_OUT
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_PORTS != typec_orient_pkg::NUM_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must match the package carrier width");
  end

  // The synchroniser below is written out as exactly two stages
  if (typec_orient_pkg::SYNC_STAGES != 2) begin : g_bad_sync
    $error("SYNC_STAGES must be 2");
  end

  // The allow mask and both enable fields must fit the bus word
  if (typec_orient_pkg::CTRL_ALLOW_LSB + NUM_PORTS > typec_orient_pkg::DATA_W) begin : g_bad_ctrl
    $error("allow mask does not fit the data word");
  end

  if (typec_orient_pkg::STATE_A_LSB + NUM_PORTS > typec_orient_pkg::STATE_B_LSB) begin : g_bad_a
    $error("orientation A field overlaps orientation B field");
  end

  if (typec_orient_pkg::STATE_B_LSB + NUM_PORTS > typec_orient_pkg::STATE_MODE_BIT) begin : g_bad_b
    $error("orientation B field overlaps the mode bit");
  end

  if (typec_orient_pkg::STATE_POL_BIT >= typec_orient_pkg::DATA_W) begin : g_bad_pol
    $error("polarity bit lies outside the data word");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  typec_orient_pkg::pin_bundle_t pins_raw;
  typec_orient_pkg::pin_bundle_t meta_r;
  typec_orient_pkg::pin_bundle_t pins_r;
  typec_orient_pkg::pin_bundle_t meta_nxt;
  typec_orient_pkg::pin_bundle_t pins_nxt;

  assign pins_raw = '{port_attach:         PORT_ATTACH_IN,
                      port_orient:         PORT_ORIENT_IN,
                      orient_a_attach:     ORIENT_A_ATTACH_IN,
                      orient_b_attach:     ORIENT_B_ATTACH_IN,
                      attach_polarity_sel: ATTACH_POLARITY_SEL_IN,
                      control_mode_sel:    CONTROL_MODE_SEL_IN};

  // Reset clears both stages, so a floating pulled-down strap reads low
  always_comb begin
    meta_nxt = meta_r;
    pins_nxt = pins_r;
    if (RST_IN) begin
      meta_nxt = typec_orient_pkg::PINS_RST;
      pins_nxt = typec_orient_pkg::PINS_RST;
    end else if (CLK_EN_IN) begin
      meta_nxt = pins_raw;
      pins_nxt = meta_r;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    meta_r <= meta_nxt;
    pins_r <= pins_nxt;
  end

  // ----------------------------------------------------------------
  // Lane decode
  // ----------------------------------------------------------------
  // Mode and polarity are used as sampled each cycle; they are expected to
  // be static, so no glitch filtering is spent on them.
  typec_orient_pkg::control_mode_t mode;
  logic                            pol_low;
  logic [NUM_PORTS-1:0]            allow_r;
  logic [NUM_PORTS-1:0]            allow_nxt;
  typec_orient_pkg::phy_en_t       phy_en_r;
  typec_orient_pkg::phy_en_t       phy_en_nxt;
  typec_orient_pkg::phy_en_t       phy_dec;

  assign mode    = typec_orient_pkg::control_mode_t'(pins_r.control_mode_sel);
  assign pol_low = pins_r.attach_polarity_sel;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic attach;
    logic orient_b;
    logic a_att;
    logic b_att;

    // XOR with the polarity flips every input to active low when set
    assign attach   = pins_r.port_attach[p]     ^ pol_low;
    assign orient_b = pins_r.port_orient[p]     ^ pol_low;
    assign a_att    = pins_r.orient_a_attach[p] ^ pol_low;
    assign b_att    = pins_r.orient_b_attach[p] ^ pol_low;

    always_comb begin
      case (mode)
        typec_orient_pkg::MODE_ATTACH_ORIENT: begin
          phy_dec.phy_a[p] = attach & ~orient_b;
          phy_dec.phy_b[p] = attach &  orient_b;
        end
        typec_orient_pkg::MODE_SPLIT_ATTACH: begin
          phy_dec.phy_a[p] = a_att;
          phy_dec.phy_b[p] = b_att;
        end
        default: begin
          phy_dec.phy_a[p] = 1'b0;
          phy_dec.phy_b[p] = 1'b0;
        end
      endcase
    end
  end

  // Enables stay off through hub reset and follow the decode masked by allow_r after it
  always_comb begin
    phy_en_nxt = phy_en_r;
    if (RST_IN) begin
      phy_en_nxt = typec_orient_pkg::PHY_EN_RST;
    end else if (CLK_EN_IN) begin
      phy_en_nxt.phy_a = phy_dec.phy_a & allow_r;
      phy_en_nxt.phy_b = phy_dec.phy_b & allow_r;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    phy_en_r <= phy_en_nxt;
  end

  assign PHY_A_EN_OUT = phy_en_r.phy_a;
  assign PHY_B_EN_OUT = phy_en_r.phy_b;

  // ----------------------------------------------------------------
  // Avalon-MM register slave
  // ----------------------------------------------------------------
  // An access waits exactly one cycle only while CLK_EN_IN is high; the second cycle completes it.
  // The wait costs a cycle but lets read data come from a flip-flop.
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;

  bus_state_t                           bus_r;
  bus_state_t                           bus_nxt;
  logic                                 ack;
  logic [typec_orient_pkg::DATA_W-1:0]  rdata_r;
  logic [typec_orient_pkg::DATA_W-1:0]  rdata_nxt;
  logic [typec_orient_pkg::DATA_W-1:0]  read_word;
  logic                                 req;
  logic                                 rd_take;
  logic                                 wr_take;
  logic                                 ctrl_sel;
  logic [typec_orient_pkg::DATA_W-1:0]  state_word;
  logic [typec_orient_pkg::DATA_W-1:0]  ctrl_word;

  assign req      = AVS_READ_IN | AVS_WRITE_IN;
  assign ack      = (bus_r == BUS_DONE);
  assign ctrl_sel = (AVS_ADDRESS_IN == typec_orient_pkg::LANE_CTRL_OFS);

  // Read data is captured on the first cycle, a write lands on the second,
  // at the edge where the master sees waitrequest low
  assign rd_take  = AVS_READ_IN & ~ack;
  assign wr_take  = AVS_WRITE_IN & ack & AVS_BYTEENABLE_IN[0] & ctrl_sel;

  assign AVS_WAITREQUEST_OUT = req & ~ack;
  assign AVS_READDATA_OUT    = rdata_r;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[typec_orient_pkg::CTRL_ALLOW_LSB +: NUM_PORTS] = allow_r;
  end

  always_comb begin
    state_word = '0;
    state_word[typec_orient_pkg::STATE_A_LSB +: NUM_PORTS] = phy_en_r.phy_a;
    state_word[typec_orient_pkg::STATE_B_LSB +: NUM_PORTS] = phy_en_r.phy_b;
    state_word[typec_orient_pkg::STATE_MODE_BIT]           = pins_r.control_mode_sel;
    state_word[typec_orient_pkg::STATE_POL_BIT]            = pins_r.attach_polarity_sel;
  end

  // Unmapped addresses read as zero
  always_comb begin
    case (AVS_ADDRESS_IN)
      typec_orient_pkg::LANE_CTRL_OFS: begin
        read_word = ctrl_word;
      end
      typec_orient_pkg::LANE_STATE_OFS: begin
        read_word = state_word;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------
  always_comb begin
    bus_nxt = bus_r;
    if (RST_IN) begin
      bus_nxt = BUS_IDLE;
    end else if (CLK_EN_IN) begin
      case (bus_r)
        BUS_IDLE: begin
          if (req) begin
            bus_nxt = BUS_DONE;
          end
        end
        BUS_DONE: begin
          bus_nxt = BUS_IDLE;
        end
        default: begin
          bus_nxt = BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    bus_r <= bus_nxt;
  end

  // ----------------------------------------------------------------
  // Read data and allow mask
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    allow_nxt = allow_r;
    if (RST_IN) begin
      rdata_nxt = typec_orient_pkg::RDATA_RST;
      allow_nxt = typec_orient_pkg::CTRL_ALLOW_RST;
    end else if (CLK_EN_IN) begin
      if (rd_take) begin
        rdata_nxt = read_word;
      end
      // Writes to the state word or unmapped addresses are dropped
      if (wr_take) begin
        allow_nxt = AVS_WRITEDATA_IN[typec_orient_pkg::CTRL_ALLOW_LSB +: NUM_PORTS];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    rdata_r <= rdata_nxt;
    allow_r <= allow_nxt;
  end

endmodule : typec_phy_orientation_control

`default_nettype wire
